// File: inc/dcr_pkg.sv
// Package: register map, field layout, reset values and timing constants for the dc-dc control bank
package dcr_pkg;
  // Register page and addresses
  localparam logic [7:0] SFR_PAGE_DCDC      = 8'h00;
  localparam logic [7:0] ADDR_DCDC_CONFIG   = 8'h96;
  localparam logic [7:0] ADDR_DCDC_CONTROL  = 8'h97;
  // Reset values
  localparam logic [7:0] RST_DCDC_CONTROL   = 8'h21;
  localparam logic [7:0] RST_DCDC_CONFIG    = 8'h00;
  // Writable bit masks (reserved bits read zero)
  localparam logic [7:0] MASK_DCDC_CONTROL  = 8'hEF;
  localparam logic [7:0] MASK_DCDC_CONFIG   = 8'h7F;
  // Control field positions
  localparam int CTL_MINPW_LSB  = 6;
  localparam int CTL_SWITCH_BIT = 5;
  localparam int CTL_RSVD_BIT   = 4;
  localparam int CTL_SYNC_BIT   = 3;
  localparam int CTL_VSEL_LSB   = 0;
  // Configuration field positions
  localparam int CFG_DIV_LSB    = 5;
  localparam int CFG_ADCINV_BIT = 4;
  localparam int CFG_CONVERTER_CLOCK_INVERT_BIT = 3;
  localparam int CFG_ILIM_BIT   = 2;
  localparam int CFG_SLEEP_BIT  = 1;
  localparam int CFG_SRC_BIT    = 0;
  // Minimum pulse width figures and cycle counts at the 20 MHz system clock
  localparam int CLK_PERIOD_NS  = 50;
  localparam int MINPW1_NS      = 20;
  localparam int MINPW2_NS      = 40;
  localparam int MINPW3_NS      = 80;
  localparam logic [2:0] MINPW1_CYC = 3'((MINPW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] MINPW2_CYC = 3'((MINPW2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] MINPW3_CYC = 3'((MINPW3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Output voltage targets in millivolts, indexed by select code
  localparam logic [11:0] VTGT_MV [8] = '{12'd1800, 12'd1900, 12'd2000, 12'd2100,
                                         12'd2400, 12'd2700, 12'd3000, 12'd3300};
  // Converter clock source encoding
  typedef enum logic {DCR_SRC_LOCAL, DCR_SRC_SYSCLK} dcr_src_t;
endpackage

// File: verilog/dcr_dcdc_regs.sv
// Dc-dc converter control and configuration register bank with decoded controls
`timescale 1ns/1ps
// Overview of operation
// - Minimum pulse width field 00 none, 01 20ns, 10 40ns, 11 80ns.
// - Control bit 5 zero picks large switches, one picks small switches.
// - Control bit 3 synchronizes ADC tracking and clock to switching cycle.
// - Voltage code 000..111 targets 1.8,1.9,2.0,2.1,2.4,2.7,3.0,3.3 volts.
// - Reset gives small switches, no minimum width, no sync, 1.9 volts.
// - Control sits at 0x97, configuration at 0x96, both on page 0x0.
// - System clock source divided by 1,2,4 or 8; ignored on local oscillator. Here setting 00 gives half rate, the same as 01.
// - Source select zero uses local oscillator, one uses system clock.
// - In sleep, sleep bit zero ties output to battery, one floats it.
// - With sync, ADC clock invert bit zero inverts, one leaves uninverted.
module dcr_dcdc_regs (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [7:0]   sfrPage,
  input  wire logic [7:0]   sfrAddr,
  input  wire logic         sfrWrite,
  input  wire logic         sfrRead,
  input  wire logic [7:0]   sfrWdata,
  input  wire logic         sleepMode,
  input  wire logic         localOscClk,
  input  wire logic         adcSarClk,
  output logic      [7:0]   sfrRdata,
  output logic              sfrRvalid,
  output logic      [2:0]   outputVoltageSel,
  output logic      [11:0]  targetMillivolts,
  output logic      [1:0]   minPulseWidthSel,
  output logic      [2:0]   minPulseCycles,
  output logic              minPulseEnable,
  output logic              switchSizeSmall,
  output logic              adcSyncEnable,
  output logic              peakCurrentLimitSel,
  output logic              converterClockSourceSel,
  output logic              converterClk,
  output logic              adcSyncClk,
  output logic              supplyToBattery,
  output logic              supplyFloating
);
  import dcr_pkg::*;

  // Control register layout, reset value 0x21
  //   [7:6] minimum pulse width select, zero means no minimum
  //   [5]   switch size, one picks the small switches
  //   [4]   reserved, masked on write so it reads back zero
  //   [3]   ADC synchronisation enable
  //   [2:0] output voltage select
  // Configuration register layout, reset value 0x00
  //   [7]   reserved, always reads zero
  //   [6:5] system clock divider for the converter clock
  //   [4]   ADC sync clock invert, zero inverts while synchronised
  //   [3]   system clock invert after the divider
  //   [2]   peak current limit, one is the higher threshold
  //   [1]   sleep connection, one floats the supply output
  //   [0]   converter clock source, one is the system clock

  // Register storage
  logic [7:0] controlReg_r;
  logic [7:0] configReg_r;
  // Free-running divider state
  logic [2:0] divCount_r;
  logic       divClk_r;
  // Address decode strobes
  logic       selControl;
  logic       selConfig;

  // Decode one register access on page zero
  // The page must match too, so other pages never alias these addresses
  function automatic logic hit(input logic [7:0] page, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = (page == SFR_PAGE_DCDC) && (addr == target);
  endfunction

  // Select strobes for the two registers
  assign selControl = hit(sfrPage, sfrAddr, ADDR_DCDC_CONTROL);
  assign selConfig  = hit(sfrPage, sfrAddr, ADDR_DCDC_CONFIG);

  // Control register; reserved bit dropped so a stray one cannot reach the converter
  // Writes to any other page or address leave it untouched
  // A write takes effect at the edge that samples the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      controlReg_r <= RST_DCDC_CONTROL;
    end else if (sfrWrite && selControl) begin
      controlReg_r <= sfrWdata & MASK_DCDC_CONTROL;
    end
  end

  // Configuration register; bit 7 is read-only zero
  // Masked the same way, so a stray one in bit 7 never sticks
  // Every field here is plain storage; decoding happens further down
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      configReg_r <= RST_DCDC_CONFIG;
    end else if (sfrWrite && selConfig) begin
      configReg_r <= sfrWdata & MASK_DCDC_CONFIG;
    end
  end

  // Read port, one cycle latency; unmapped addresses return zero
  // A read and a write in one cycle return the value held before the write
  // Unmapped reads still answer, so the core never waits on this bank
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sfrRdata  <= 8'h00;
      sfrRvalid <= 1'b0;
    end else begin
      sfrRvalid <= sfrRead;
      if (sfrRead && selControl) begin
        sfrRdata <= controlReg_r;
      end else if (sfrRead && selConfig) begin
        sfrRdata <= configReg_r;
      end else begin
        sfrRdata <= 8'h00;
      end
    end
  end

  // Output voltage select and its target in millivolts move together
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outputVoltageSel <= RST_DCDC_CONTROL[CTL_VSEL_LSB +: 3];
      targetMillivolts <= VTGT_MV[RST_DCDC_CONTROL[CTL_VSEL_LSB +: 3]];
    end else begin
      outputVoltageSel <= controlReg_r[CTL_VSEL_LSB +: 3];
      targetMillivolts <= VTGT_MV[controlReg_r[CTL_VSEL_LSB +: 3]];
    end
  end

  // Minimum pulse width as a count of system clock cycles, rounded up
  // At one cycle per 50 ns the 20 and 40 ns settings both give one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      minPulseWidthSel <= RST_DCDC_CONTROL[CTL_MINPW_LSB +: 2];
      minPulseCycles   <= 3'h0;
      minPulseEnable   <= 1'b0;
    end else begin
      minPulseWidthSel <= controlReg_r[CTL_MINPW_LSB +: 2];
      minPulseEnable   <= controlReg_r[CTL_MINPW_LSB +: 2] != 2'h0;
      case (controlReg_r[CTL_MINPW_LSB +: 2])
        2'h1:    minPulseCycles <= MINPW1_CYC;
        2'h2:    minPulseCycles <= MINPW2_CYC;
        2'h3:    minPulseCycles <= MINPW3_CYC;
        default: minPulseCycles <= 3'h0;
      endcase
    end
  end

  // Switch size, sync enable and current limit go straight to the converter
  // The limit sits in the configuration register but is decoded with the rest
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      switchSizeSmall     <= RST_DCDC_CONTROL[CTL_SWITCH_BIT];
      adcSyncEnable       <= RST_DCDC_CONTROL[CTL_SYNC_BIT];
      peakCurrentLimitSel <= RST_DCDC_CONFIG[CFG_ILIM_BIT];
    end else begin
      switchSizeSmall     <= controlReg_r[CTL_SWITCH_BIT];
      adcSyncEnable       <= controlReg_r[CTL_SYNC_BIT];
      peakCurrentLimitSel <= configReg_r[CFG_ILIM_BIT];
    end
  end

  // System clock divider; counter runs always so a divider change takes effect at the next edge
  // Divide by one and by two both toggle every edge; no flop can give full rate
  // The counter is never cleared by a write, so a new divider starts mid-count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      divCount_r <= 3'h0;
      divClk_r   <= 1'b0;
    end else begin
      divCount_r <= divCount_r + 3'h1;
      case (configReg_r[CFG_DIV_LSB +: 2])
        2'h0:    divClk_r <= ~divClk_r;
        2'h1:    divClk_r <= divCount_r[0];
        2'h2:    divClk_r <= divCount_r[1];
        default: divClk_r <= divCount_r[2];
      endcase
    end
  end

  // Source mux and inversion; a registered clock limits divide-by-1 to half rate
  // Inversion applies only to the system clock path; the oscillator passes as sampled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      converterClockSourceSel <= RST_DCDC_CONFIG[CFG_SRC_BIT];
      converterClk            <= 1'b0;
    end else begin
      converterClockSourceSel <= configReg_r[CFG_SRC_BIT];
      if (configReg_r[CFG_SRC_BIT] == DCR_SRC_SYSCLK) begin
        converterClk <= divClk_r ^ configReg_r[CFG_CONVERTER_CLOCK_INVERT_BIT];
      end else begin
        converterClk <= localOscClk;
      end
    end
  end

  // ADC clock: synchronised copy of the converter clock, else the free ADC clock
  // It trails the converter clock by one cycle, as it reads the registered copy
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adcSyncClk <= 1'b0;
    end else if (controlReg_r[CTL_SYNC_BIT]) begin
      adcSyncClk <= converterClk ^ ~configReg_r[CFG_ADCINV_BIT];
    end else begin
      adcSyncClk <= adcSarClk;
    end
  end

  // Sleep connection of the supply output
  // Converter enable is a strap outside this bank, so sleep alone decides here
  // Both outputs stay low while awake, so the supply output is driven normally
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supplyToBattery <= 1'b0;
      supplyFloating  <= 1'b0;
    end else begin
      supplyToBattery <= sleepMode && !configReg_r[CFG_SLEEP_BIT];
      supplyFloating  <= sleepMode && configReg_r[CFG_SLEEP_BIT];
    end
  end
endmodule

// File: verification/dcr_dcdc_regs_assertions.sv
// Checker: port relations of the dc-dc control register bank
`timescale 1ns/1ps
module dcr_dcdc_regs_assertions
  import dcr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  sfrPage,
  input wire logic [7:0]  sfrAddr,
  input wire logic        sfrWrite,
  input wire logic        sfrRead,
  input wire logic [7:0]  sfrWdata,
  input wire logic        sleepMode,
  input wire logic [7:0]  sfrRdata,
  input wire logic        sfrRvalid,
  input wire logic [2:0]  outputVoltageSel,
  input wire logic [11:0] targetMillivolts,
  input wire logic [1:0]  minPulseWidthSel,
  input wire logic [2:0]  minPulseCycles,
  input wire logic        switchSizeSmall,
  input wire logic        supplyToBattery,
  input wire logic        supplyFloating
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Read answers come one cycle late, and nothing shows on the data bus otherwise
  a_read_answer: assert property (sfrRead |=> sfrRvalid) else $error("no read answer");
  a_idle_rdata: assert property (!sfrRvalid |-> sfrRdata == 8'h00) else $error("rdata idle");
  a_unmapped_zero: assert property (sfrRead && sfrAddr[7:1] != 7'h4B |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  // Decoded control outputs land two edges after the write strobe
  a_ctl_decode: assert property (sfrWrite && sfrPage == 8'h00 && sfrAddr == 8'h97 |-> ##2
    {minPulseWidthSel, switchSizeSmall, outputVoltageSel} ==
    {$past(sfrWdata[7:5], 2), $past(sfrWdata[2:0], 2)}) else $error("control decode");
  a_vsel_target: assert property (targetMillivolts == VTGT_MV[outputVoltageSel])
    else $error("voltage target");
  a_min_cycles: assert property (minPulseCycles ==
    (minPulseWidthSel == 2'h3 ? 3'h2 : {2'h0, |minPulseWidthSel})) else $error("min pulse");
  // Sleep routing uses one register stage, so it trails sleepMode by one edge
  a_sleep_route: assert property ($past(rst_n) |->
    (supplyToBattery || supplyFloating) == $past(sleepMode)) else $error("sleep route");
  a_sleep_exclusive: assert property (!(supplyToBattery && supplyFloating))
    else $error("sleep both");
  a_reset_state: assert property ($rose(rst_n) |-> outputVoltageSel == 3'h1 &&
    switchSizeSmall && minPulseWidthSel == 2'h0 && !sfrRvalid) else $error("reset state");
  c_read: cover property (sfrRvalid);
  c_float: cover property (supplyFloating);
  c_long_pulse: cover property (minPulseCycles == 3'h2);
endmodule

// File: verification/dcr_dcdc_regs_tb.sv
// Testbench: register access, field decode, sleep routing and clock divider
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t mismatch %h vs %h", $time, a, b); end end
module dcr_dcdc_regs_tb;
  import dcr_pkg::*;
  logic        clock = 0, rst_n = 0, sfrWrite = 0, sfrRead = 0, sleepMode = 0;
  logic        localOscClk = 0, adcSarClk = 0, p;
  logic [7:0]  sfrPage = 0, sfrAddr = 0, sfrWdata = 0, sfrRdata;
  logic        sfrRvalid, minPulseEnable, switchSizeSmall, adcSyncEnable, adcSyncClk;
  logic        peakCurrentLimitSel, converterClockSourceSel, converterClk;
  logic        supplyToBattery, supplyFloating;
  logic [2:0]  outputVoltageSel, minPulseCycles;
  logic [1:0]  minPulseWidthSel;
  logic [11:0] targetMillivolts;
  logic [11:0] mv [8] = '{12'd1800, 12'd1900, 12'd2000, 12'd2100,
                          12'd2400, 12'd2700, 12'd3000, 12'd3300};
  logic [2:0]  cyc [4] = '{3'h0, 3'h1, 3'h1, 3'h2};
  int          err_count = 0, tests_run = 0, n;
  int          exp [5] = '{16, 16, 8, 4, 16};
  dcr_dcdc_regs dcr_dcdc_regs_inst (
    .clock                   (clock),
    .rst_n                   (rst_n),
    .sfrPage                 (sfrPage),
    .sfrAddr                 (sfrAddr),
    .sfrWrite                (sfrWrite),
    .sfrRead                 (sfrRead),
    .sfrWdata                (sfrWdata),
    .sleepMode               (sleepMode),
    .localOscClk             (localOscClk),
    .adcSarClk               (adcSarClk),
    .sfrRdata                (sfrRdata),
    .sfrRvalid               (sfrRvalid),
    .outputVoltageSel        (outputVoltageSel),
    .targetMillivolts        (targetMillivolts),
    .minPulseWidthSel        (minPulseWidthSel),
    .minPulseCycles          (minPulseCycles),
    .minPulseEnable          (minPulseEnable),
    .switchSizeSmall         (switchSizeSmall),
    .adcSyncEnable           (adcSyncEnable),
    .peakCurrentLimitSel     (peakCurrentLimitSel),
    .converterClockSourceSel (converterClockSourceSel),
    .converterClk            (converterClk),
    .adcSyncClk              (adcSyncClk),
    .supplyToBattery         (supplyToBattery),
    .supplyFloating          (supplyFloating)
  );
  initial forever #25 clock = ~clock;
  // Local oscillator stand-in toggles every cycle so its path is visible
  always @(posedge clock) localOscClk <= ~localOscClk;
  // ADC clock stand-in changes every second cycle, unlike the oscillator
  always @(posedge clock) if (localOscClk) adcSarClk <= ~adcSarClk;
  task automatic wr(input logic [7:0] pg, a, d);
    @(posedge clock);
    {sfrPage, sfrAddr, sfrWdata, sfrWrite} <= {pg, a, d, 1'b1};
    @(posedge clock);
    sfrWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock);
    {sfrPage, sfrAddr, sfrRead} <= {8'h00, a, 1'b1};
    @(posedge clock);
    sfrRead <= 1'b0;
    #1 `CHK(sfrRdata, e)
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h97, 8'h21);
    rd(8'h96, 8'h00);
    `CHK(targetMillivolts, 12'd1900)
    wr(8'h00, 8'h97, 8'hEF);
    rd(8'h97, 8'hEF);
    wr(8'h01, 8'h97, 8'h00);
    rd(8'h97, 8'hEF);
    rd(8'h98, 8'h00);
    // Walk every voltage code with pulse width, switch and sync varied alongside
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'h97, {i[1:0], ~i[0], 1'b0, i[0], i[2:0]});
      @(posedge clock);
      #1 `CHK(targetMillivolts, mv[i])
      `CHK(minPulseCycles, cyc[i[1:0]])
      `CHK(minPulseEnable, i[1:0] != 2'h0)
      `CHK({switchSizeSmall, adcSyncEnable}, {~i[0], i[0]})
    end
    wr(8'h00, 8'h96, 8'hFF);
    rd(8'h96, 8'h7F);
    `CHK({peakCurrentLimitSel, converterClockSourceSel}, 2'h3)
    @(posedge clock) sleepMode <= 1'b1;
    repeat (2) @(posedge clock);
    #1 `CHK({supplyToBattery, supplyFloating}, 2'h1)
    wr(8'h00, 8'h96, 8'h00);
    @(posedge clock);
    #1 `CHK({supplyToBattery, supplyFloating}, 2'h2)
    // Count output edges over 16 cycles; phase does not change the count
    // ADC invert follows i while sync stays on from the last control write
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, 8'h96, i < 4 ? {1'b0, i[1:0], i[0], 4'h1} : 8'h60);
      repeat (4) @(posedge clock);
      #1 p = converterClk;
      n = 0;
      repeat (16) begin
        @(posedge clock);
        #1 n += int'(converterClk !== p);
        `CHK(adcSyncClk, (i < 4 && i[0]) ? p : ~p)
        p = converterClk;
      end
      `CHK(n, exp[i])
    end
    // Same phase of the divide-by-8 count, system clock invert flipped between
    wr(8'h00, 8'h96, 8'h61);
    repeat (4) @(posedge clock);
    #1 p = converterClk;
    wr(8'h00, 8'h96, 8'h69);
    repeat (6) @(posedge clock);
    #1 `CHK(converterClk, ~p)
    // Sync off: the free ADC clock passes through one cycle late
    wr(8'h00, 8'h97, 8'h21);
    repeat (2) @(posedge clock);
    repeat (8) begin
      #1 p = adcSarClk;
      @(posedge clock);
      #1 `CHK(adcSyncClk, p)
    end
    end_of_test();
  end
endmodule
bind dcr_dcdc_regs dcr_dcdc_regs_assertions dcr_dcdc_regs_assertions_inst (
  .clock            (clock),
  .rst_n            (rst_n),
  .sfrPage          (sfrPage),
  .sfrAddr          (sfrAddr),
  .sfrWrite         (sfrWrite),
  .sfrRead          (sfrRead),
  .sfrWdata         (sfrWdata),
  .sleepMode        (sleepMode),
  .sfrRdata         (sfrRdata),
  .sfrRvalid        (sfrRvalid),
  .outputVoltageSel (outputVoltageSel),
  .targetMillivolts (targetMillivolts),
  .minPulseWidthSel (minPulseWidthSel),
  .minPulseCycles   (minPulseCycles),
  .switchSizeSmall  (switchSizeSmall),
  .supplyToBattery  (supplyToBattery),
  .supplyFloating   (supplyFloating)
);
